// file: core/port_mode_defs.vh
// constants of the port mode select block: register indices, field
// positions, reset values and state codes; definitions only.
// assumes inclusion by bare name from the design files.
//
// How it works
// - each port 2 direction bit: 0 makes the line output, 1 input
// - port 2 direction register sits at index f6, write-only, reads zero
// - drive-select bit: 0 open-drain port 2 outputs, 1 active pull-up
// - port 0 handshake bit: 0 line2 in/line5 out, 1 strobe pair
// - two-bit field sets lines 3,4: out, in, memory select, handshake
// - port 2 handshake bit: 0 timer in/out on lines 1,6, 1 strobes
// - serial bit: 0 plain line0/line7, 1 serial receive and transmit
// - parity bit: 0 parity off on serial channel, 1 parity on while serial bit is 1
// - port 3 config register sits at index f7, write-only
// - port 2 strobe roles follow direction of port 2 line 7
`ifndef PORT_MODE_DEFS_VH
`define PORT_MODE_DEFS_VH

// --------------------------------------------------------------
// register indices; byte address is four times the index
// --------------------------------------------------------------
`define IDX_PORT2_DIRECTION   8'hf6
`define IDX_PORT3_FUNC_SELECT 8'hf7
`define IDX_PORT01_CONFIG     8'hf8
`define IDX_PORT_STATUS       8'hf9

// --------------------------------------------------------------
// port3_function_select field positions
// --------------------------------------------------------------
`define P3_PULLUP_BIT   0
`define P3_RSVD_BIT     1
`define P3_HS0_BIT      2
`define P3_L34_LO       3
`define P3_L34_HI       4
`define P3_HS2_BIT      5
`define P3_SERIAL_BIT   6
`define P3_PARITY_BIT   7

// line 3/4 field codes
`define L34_PLAIN       2'h0
`define L34_IN          2'h1
`define L34_DMEM        2'h2
`define L34_HSHAKE      2'h3

// port0_port1_config: bits giving handshake direction (1 = input)
`define P01_P0_IN_BIT   0
`define P01_P1_IN_BIT   1

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define RST_PORT2_DIRECTION   8'hff
`define RST_PORT3_FUNC_SELECT 8'h00
`define RST_PORT01_CONFIG     8'h00

// handshake state codes, one-hot
`define HS_IDLE  3'h1
`define HS_HOLD  3'h2
`define HS_DRAIN 3'h4

`endif

// file: core/handshake_strobe.v
// one handshake pair: one strobe line in from the peer, one driven out.
// assumes peerLine already synchronised; strobes are active low.
`timescale 1ns/1ps
`include "port_mode_defs.vh"

module handshake_strobe (
  input  wire clk_sys,
  input  wire rst_b,
  input  wire enable,
  input  wire sendMode,
  input  wire loadReq,
  input  wire peerLine,
  output reg  ownLine_r,
  output reg  done_r,
  output reg  capture_r,
  output wire busy
);

  reg [2:0] state_r;

  assign busy = ~state_r[0];

  // ------------------------------------------------------------
  // strobe sequencing
  // ------------------------------------------------------------
  // send: data valid low, wait ack low, release, wait ack high.
  // receive: wait valid low, ack low, wait valid high, release.
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r   <= `HS_IDLE;
      ownLine_r <= 1'b1;
      done_r    <= 1'b0;
      capture_r <= 1'b0;
    end else if (!enable) begin
      state_r   <= `HS_IDLE;
      ownLine_r <= 1'b1;
      done_r    <= 1'b0;
      capture_r <= 1'b0;
    end else begin
      done_r    <= 1'b0;
      capture_r <= 1'b0;
      case (state_r)
        `HS_IDLE: begin
          if (sendMode && loadReq) begin
            ownLine_r <= 1'b0;
            state_r   <= `HS_HOLD;
          end else if (!sendMode && !peerLine) begin
            ownLine_r <= 1'b0;
            capture_r <= 1'b1;
            state_r   <= `HS_DRAIN;
          end
        end
        `HS_HOLD: begin
          if (!peerLine) begin
            ownLine_r <= 1'b1;
            done_r    <= 1'b1;
            state_r   <= `HS_DRAIN;
          end
        end
        `HS_DRAIN: begin
          // no new transfer until the peer strobe returns high
          if (peerLine) begin
            ownLine_r <= 1'b1;
            state_r   <= `HS_IDLE;
          end
        end
        default: begin
          state_r   <= `HS_IDLE;
          ownLine_r <= 1'b1;
        end
      endcase
    end
  end

endmodule

// file: core/port_mode_select.v
// port mode select: write-only configuration of port 2 direction and
// drive, and of the roles of the eight port 3 lines.
// assumes an AHB-Lite master on clk_sys and pins that pass a 2-ff sync.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "port_mode_defs.vh"

module port_mode_select (
  input  wire        clk_sys,
  input  wire        rst_b,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  // port 2 pads and core data
  input  wire [7:0]  port2Data,
  output reg  [7:0]  port2Out,
  output reg  [7:0]  port2Oe,
  output reg         port2PullUp,
  // port 3 pads (lines 0..3 input, 4..7 output)
  input  wire [3:0]  port3In,
  input  wire [7:4]  port3Data,
  output reg  [7:4]  port3Out,
  output reg  [3:0]  port3InSync,
  // alternate functions
  input  wire        serialTx,
  output reg         serialRx,
  output reg         parityEn,
  input  wire        timerOut,
  output reg         timerInLine,
  input  wire        dataMemSel,
  // handshake core side, one bit per port 0,1,2
  input  wire [2:0]  hsLoad,
  output reg  [2:0]  hsDone,
  output reg  [2:0]  hsCapture
);

  // ------------------------------------------------------------
  // configuration copies
  // ------------------------------------------------------------
  reg [7:0] port2Dir_r;
  reg [7:0] port3Func_r;
  reg [7:0] port01Cfg_r;

  // bus data-phase state
  reg       wrPend_r;
  reg [7:0] wrIdx_r;

  // pin synchroniser, first stage read only by the second
  reg [3:0] pinMeta_r;
  reg [3:0] pinSync_r;

  wire [2:0] hsEnable;
  wire [2:0] hsSend;
  wire [2:0] hsLine;
  wire [2:0] hsDoneW;
  wire [2:0] hsCapW;
  wire [2:0] hsBusy;
  wire [3:0] hsPeer;

  wire       addrPhase;
  wire [7:0] addrIdx;

  // word index of a byte address, off-window bits give no match
  function [7:0] word_index;
    input [31:0] addr;
    begin
      if (addr[31:10] == 22'h0 && addr[1:0] == 2'h0)
        word_index = addr[9:2];
      else
        word_index = 8'h00;
    end
  endfunction

  assign addrPhase = hsel & hready & htrans[1];
  assign addrIdx   = word_index(haddr);

  // ------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ------------------------------------------------------------
  // read data is set up at the address phase so it comes from a flop
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0;
      wrPend_r  <= 1'b0;
      wrIdx_r   <= 8'h00;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wrPend_r  <= addrPhase & hwrite;
      if (addrPhase)
        wrIdx_r <= addrIdx;
      hrdata <= 32'h0;
      // config registers are write-only and read back zero
      if (addrPhase && !hwrite && addrIdx == `IDX_PORT_STATUS)
        hrdata <= {24'h0, hsBusy, pinSync_r, port2PullUp};
    end
  end

  // ------------------------------------------------------------
  // write-only configuration registers
  // ------------------------------------------------------------
  // held until the next write or reset, they steer every mux below
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port2Dir_r  <= `RST_PORT2_DIRECTION;
      port3Func_r <= `RST_PORT3_FUNC_SELECT;
      port01Cfg_r <= `RST_PORT01_CONFIG;
    end else if (wrPend_r) begin
      case (wrIdx_r)
        `IDX_PORT2_DIRECTION:
          port2Dir_r <= hwdata[7:0];
        `IDX_PORT3_FUNC_SELECT: begin
          port3Func_r <= hwdata[7:0];
          // reserved bit is kept zero whatever software writes
          port3Func_r[`P3_RSVD_BIT] <= 1'b0;
        end
        `IDX_PORT01_CONFIG:
          port01Cfg_r <= hwdata[7:0];
        default: begin
          port2Dir_r <= port2Dir_r;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // port 3 input synchroniser
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pinMeta_r <= 4'hf;
      pinSync_r <= 4'hf;
    end else begin
      pinMeta_r <= port3In;
      pinSync_r <= pinMeta_r;
    end
  end

  // ------------------------------------------------------------
  // handshake channels: a on lines 2/5, b on 3/4, c on 1/6
  // ------------------------------------------------------------
  assign hsPeer = pinSync_r;
  assign hsEnable[0] = port3Func_r[`P3_HS0_BIT];
  assign hsEnable[1] = (port3Func_r[`P3_L34_HI:`P3_L34_LO] == `L34_HSHAKE);
  assign hsEnable[2] = port3Func_r[`P3_HS2_BIT];
  assign hsSend[0]   = ~port01Cfg_r[`P01_P0_IN_BIT];
  assign hsSend[1]   = ~port01Cfg_r[`P01_P1_IN_BIT];
  // port 2 output direction on line 7 makes the device the sender
  assign hsSend[2]   = ~port2Dir_r[7];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : gHs
      localparam integer PEER = (gi == 0) ? 2 : (gi == 1) ? 3 : 1;
      handshake_strobe uHs (
        .clk_sys   (clk_sys),
        .rst_b     (rst_b),
        .enable    (hsEnable[gi]),
        .sendMode  (hsSend[gi]),
        .loadReq   (hsLoad[gi]),
        .peerLine  (hsPeer[PEER]),
        .ownLine_r (hsLine[gi]),
        .done_r    (hsDoneW[gi]),
        .capture_r (hsCapW[gi]),
        .busy      (hsBusy[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // port 2 pad drive
  // ------------------------------------------------------------
  // open-drain only enables the driver for a low bit
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port2Out    <= 8'h00;
      port2Oe     <= 8'h00;
      port2PullUp <= 1'b0;
    end else begin
      port2PullUp <= port3Func_r[`P3_PULLUP_BIT];
      if (port3Func_r[`P3_PULLUP_BIT]) begin
        port2Out <= port2Data;
        port2Oe  <= ~port2Dir_r;
      end else begin
        port2Out <= 8'h00;
        port2Oe  <= ~port2Dir_r & ~port2Data;
      end
    end
  end

  // ------------------------------------------------------------
  // port 3 output mux and alternate inputs
  // ------------------------------------------------------------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      port3Out    <= 4'hf;
      port3InSync <= 4'hf;
      serialRx    <= 1'b1;
      parityEn    <= 1'b0;
      timerInLine <= 1'b0;
      hsDone      <= 3'h0;
      hsCapture   <= 3'h0;
    end else begin
      port3InSync <= pinSync_r;
      hsDone      <= hsDoneW;
      hsCapture   <= hsCapW;
      // line 4: plain, memory select or channel b strobe
      case (port3Func_r[`P3_L34_HI:`P3_L34_LO])
        `L34_DMEM:   port3Out[4] <= dataMemSel;
        `L34_HSHAKE: port3Out[4] <= hsLine[1];
        default:     port3Out[4] <= port3Data[4];
      endcase
      port3Out[5] <= hsEnable[0] ? hsLine[0] : port3Data[5];
      port3Out[6] <= hsEnable[2] ? hsLine[2] : timerOut;
      port3Out[7] <= port3Func_r[`P3_SERIAL_BIT] ? serialTx : port3Data[7];
      // timer input exists only while port 2 handshake is off
      timerInLine <= hsEnable[2] ? 1'b0 : pinSync_r[1];
      // idle-high receive line while serial is off
      serialRx    <= port3Func_r[`P3_SERIAL_BIT] ? pinSync_r[0] : 1'b1;
      parityEn    <= port3Func_r[`P3_SERIAL_BIT] & port3Func_r[`P3_PARITY_BIT];
    end
  end

endmodule

// file: tb/port_mode_select_sva.sv
// checker: bus answers, config fan-out and pin routing of port_mode_select
// assumes zero-wait single-word writes; shadows the port 2 direction and port 3 select registers
`timescale 1ns/1ps
module port_mode_select_sva (
  input wire        clk_sys,
  input wire        rst_b,
  input wire        hsel,
  input wire [31:0] haddr,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire [31:0] hwdata,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire [7:0]  port2Data,
  input wire [7:0]  port2Out,
  input wire [7:0]  port2Oe,
  input wire        port2PullUp,
  input wire [3:0]  port3In,
  input wire [3:0]  port3InSync,
  input wire [7:4]  port3Out,
  input wire [7:4]  port3Data,
  input wire        timerOut,
  input wire        serialTx,
  input wire        serialRx,
  input wire        parityEn,
  input wire        timerInLine,
  input wire        dataMemSel,
  input wire [2:0]  hsDone
);
  logic        wrPend_r;
  logic [31:0] wrAddr_r;
  logic [7:0]  dir_r;
  logic [7:0]  cfg_r;
  logic        armed_r;
  // first edge after release still shows the reset values of the pins
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) armed_r <= 1'b0;
    else armed_r <= 1'b1;
  end
  // ----------
  // shadow copy, needed because the registers cannot be read back
  // ----------
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wrPend_r <= 1'b0;
      wrAddr_r <= 32'h0;
      dir_r    <= 8'hff;
      cfg_r    <= 8'h00;
    end else if (hready) begin
      wrPend_r <= hsel && htrans[1] && hwrite;
      wrAddr_r <= haddr;
      if (wrPend_r && wrAddr_r == 32'h3d8) dir_r <= hwdata[7:0];
      if (wrPend_r && wrAddr_r == 32'h3dc) cfg_r <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  a_read_zero: assert property (
    hsel && hready && htrans[1] && !hwrite && haddr != 32'h3e4 |=> hrdata == 32'h0) else $error("write-only read not zero");
  a_dir_drive: assert property (
    port2Oe == (~$past(dir_r) & ($past(cfg_r[0]) ? 8'hff : ~$past(port2Data))))
    else $error("port 2 enables off");
  a_pad_data: assert property (
    port2Out == ($past(cfg_r[0]) ? $past(port2Data) : 8'h00)) else $error("port 2 pad data off");
  a_line5_plain: assert property (
    armed_r && !$past(cfg_r[2]) |-> port3Out[5] == $past(port3Data[5])) else $error("line 5 not plain");
  a_line4_plain: assert property (
    armed_r && !$past(cfg_r[4]) |-> port3Out[4] == $past(port3Data[4])) else $error("line 4 not plain");
  a_line6_timer: assert property (
    armed_r && !$past(cfg_r[5]) |-> port3Out[6] == $past(timerOut)) else $error("timer output not routed");
  a_drive_mode: assert property (port2PullUp == $past(cfg_r[0])) else $error("drive mode off");
  a_parity_gate: assert property (parityEn == ($past(cfg_r[6]) && $past(cfg_r[7]))) else $error("parity off");
  a_rx_idle: assert property (!$past(cfg_r[6]) |-> serialRx) else $error("receive not idle");
  a_tx_route: assert property (
    $past(cfg_r[6]) |-> port3Out[7] == $past(serialTx)) else $error("transmit not routed");
  a_dmem_route: assert property (
    $past(cfg_r[4:3]) == 2'h2 |-> port3Out[4] == $past(dataMemSel)) else $error("memory select not routed");
  a_timer_gate: assert property ($past(cfg_r[5]) |-> !timerInLine) else $error("timer input not gated");
  a_sync_delay: assert property (port3InSync == $past(port3In, 3)) else $error("sync latency off");
  a_done_pulse: assert property (
    |hsDone |=> !(|(hsDone & $past(hsDone)))) else $error("done longer than one cycle");
endmodule
bind port_mode_select port_mode_select_sva u_sva (.*);

// file: tb/strobe_peer.sv
// partner: peer logic acknowledging the device's outgoing strobes
// assumes active-low strobes; dly sets how slowly it answers
`timescale 1ns/1ps
module strobe_peer (
  input  wire       clk_sys,
  input  wire       rst_b,
  input  wire [3:0] dly,
  input  wire [2:0] ackMask,
  input  wire [3:0] idleIn,
  input  wire [7:4] port3Out,
  output wire [3:0] port3In
);
  logic [2:0] ackLow_r;
  logic [3:0] cnt_r [3];
  wire  [2:0] outLow = {~port3Out[6], ~port3Out[4], ~port3Out[5]};
  // ack only after the strobe, drop it once the strobe is back
  always @(posedge clk_sys or negedge rst_b) begin
    for (int k = 0; k < 3; k++) begin
      if (!rst_b || !outLow[k]) begin
        ackLow_r[k] <= 1'b0;
        cnt_r[k]    <= 4'h0;
      end else if (cnt_r[k] == dly) begin
        ackLow_r[k] <= 1'b1;
      end else begin
        cnt_r[k] <= cnt_r[k] + 4'h1;
      end
    end
  end
  // lines outside handshake take the bench's levels
  assign port3In = {ackMask[1] ? ~ackLow_r[1] : idleIn[3], ackMask[0] ? ~ackLow_r[0] : idleIn[2],
                    ackMask[2] ? ~ackLow_r[2] : idleIn[1], idleIn[0]};
endmodule

// file: tb/port_mode_select_tb_top.sv
// bench: bus tasks, config sweeps and handshake transfers
// assumes a zero-wait slave and strobe_peer on port 3
`timescale 1ns/1ps
module port_mode_select_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [7:0]  port2Data = 8'h00;
  logic [7:4]  port3Data = 4'h0;
  logic        serialTx = 1'b1;
  logic        timerOut = 1'b0;
  logic        dataMemSel = 1'b0;
  logic [2:0]  hsLoad = 3'h0;
  logic [3:0]  dly = 4'h0;
  logic [2:0]  ackMask = 3'h0;
  logic [3:0]  idleIn = 4'hf;
  wire         hreadyout, hresp, port2PullUp, serialRx, parityEn, timerInLine;
  wire  [31:0] hrdata;
  wire  [7:0]  port2Out, port2Oe;
  wire  [7:4]  port3Out;
  wire  [3:0]  port3In, port3InSync;
  wire  [2:0]  hsDone, hsCapture;
  wire         hsel = 1'b1;
  wire         hready = hreadyout;
  wire  [2:0]  hsize = 3'h2;
  logic [15:0] seed = 16'h000f;
  logic [31:0] rd;
  logic [7:0]  v;
  logic [7:0]  p2Prev = 8'h00;
  int          miscompares = 0;
  int          nTests = 0;
  int          cyc = 0;
  int          n;
  port_mode_select i_dut (.*);
  strobe_peer      u_peer (.*);
  always #12.5 clk_sys = ~clk_sys;
  function automatic [15:0] lfsr(input [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // expected {pull-up, parity, receive, timer input} for a config byte
  function automatic [3:0] expCfg(input [7:0] c, input [3:0] idle);
    expCfg = {c[0], c[6] & c[7], c[6] ? idle[0] : 1'b1, c[5] ? 1'b0 : idle[1]};
  endfunction
  task check(input logic [31:0] seen, input logic [31:0] exp);
    nTests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    if (miscompares == 0 && nTests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // one single transfer; hready is sampled at each phase's closing edge
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_sys);
    while (!hreadyout) @(posedge clk_sys);
    rd = hrdata;
  endtask
  task read_all_zero;
    for (int a = 0; a < 4; a++) begin
      bus(1'b0, (a == 3) ? 32'h100 : 32'h3d8 + 4 * a, 32'h0);
      check(rd, 32'h0);
    end
  endtask
  // ----------
  // random core-side inputs and hang guard
  // ----------
  always @(posedge clk_sys) begin
    seed       <= lfsr(seed);
    port2Data  <= seed[15:8];
    p2Prev     <= port2Data;
    port3Data  <= seed[7:4];
    {serialTx, timerOut, dataMemSel} <= seed[2:0];
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    check(port2Oe, 8'h00);
    read_all_zero();
    for (int i = 0; i < 8; i++) begin
      v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
      bus(1'b1, 32'h3d8, {24'h0, v});
      repeat (2) @(posedge clk_sys);
      check(port2Oe, {24'h0, ~v & ~p2Prev});
      check(port2Out, 32'h0);
    end
    // every line 3/4 code; reserved bit kept zero
    for (int i = 0; i < 8; i++) begin
      v = {seed[7:5], i[1:0], seed[2], 1'b0, seed[0]};
      idleIn <= seed[11:8];
      bus(1'b1, 32'h3dc, {24'h0, v});
      repeat (6) @(posedge clk_sys);
      check({port2PullUp, parityEn, serialRx, timerInLine}, expCfg(v, idleIn));
      check(port2Out, {24'h0, v[0] ? p2Prev : 8'h00});
    end
    // send on channels a, b, c with prompt and slow peer
    for (int k = 0; k < 3; k++) begin
      idleIn <= 4'hf;
      bus(1'b1, 32'h3e0, 32'h0);
      bus(1'b1, 32'h3d8, 32'h7f);
      bus(1'b1, 32'h3dc, (k == 0) ? 32'h04 : (k == 1) ? 32'h18 : 32'h20);
      ackMask <= 3'(1 << k);
      dly <= 4'(k * 4);
      repeat (4) @(posedge clk_sys);
      hsLoad <= 3'(1 << k);
      @(posedge clk_sys);
      hsLoad <= 3'h0;
      for (n = 0; !hsDone[k] && n < 60; n++) @(posedge clk_sys);
      check(hsDone[k], 1'b1);
      repeat (12) @(posedge clk_sys);
    end
    // all channels receive; line 7 input makes channel c receive
    ackMask <= 3'h0;
    bus(1'b1, 32'h3e0, 32'h03);
    bus(1'b1, 32'h3d8, 32'hff);
    bus(1'b1, 32'h3dc, 32'h3c);
    idleIn <= 4'h1;
    for (n = 0; hsCapture != 3'h7 && n < 60; n++) @(posedge clk_sys);
    check(hsCapture, 3'h7);
    repeat (2) @(posedge clk_sys);
    check(port3Out[6:4], 3'h0);
    // status: all busy, lines 1..3 low, open-drain
    bus(1'b0, 32'h3e4, 32'h0);
    check(rd, 32'he2);
    idleIn <= 4'hf;
    for (n = 0; port3Out[6:4] != 3'h7 && n < 60; n++) @(posedge clk_sys);
    check(port3Out[6:4], 3'h7);
    read_all_zero();
    check(port2Oe, 8'h00);
    final_report();
  end
endmodule
